// >>> common/tssfc_pkg.sv
// shared constants, register map and types for the start-up and fail-safe clock controller
package tssfc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_OSC_CONTROL = 12'h000;
  localparam logic [11:0] OFS_OSC_STATUS  = 12'h004;
  localparam logic [11:0] OFS_FAIL_CTRL   = 12'h008;

  // ----------------------------------------------------------------
  // oscillator_control fields
  // ----------------------------------------------------------------
  localparam int          BIT_SOFT_PLL    = 7;
  localparam int          POS_FREQ_SEL    = 3;
  localparam int          POS_CLK_SEL     = 0;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'hFB;
  localparam logic [7:0]  CTRL_RESET      = 8'h38;
  localparam logic [1:0]  CLK_SEL_PRIMARY = 2'h0;
  localparam logic [1:0]  CLK_SEL_TIMER   = 2'h1;

  // ----------------------------------------------------------------
  // oscillator_status fields
  // ----------------------------------------------------------------
  localparam int BIT_TMR_RDY  = 7;
  localparam int BIT_PLL_RDY  = 6;
  localparam int BIT_SU_DONE  = 5;
  localparam int BIT_FAST_RDY = 4;
  localparam int BIT_FAST_LCK = 3;
  localparam int BIT_MED_RDY  = 2;
  localparam int BIT_SLOW_RDY = 1;
  localparam int BIT_FAST_STB = 0;

  // ----------------------------------------------------------------
  // fail control fields
  // ----------------------------------------------------------------
  localparam int BIT_FAIL_FLAG = 0;
  localparam int BIT_FAIL_IEN  = 1;

  // ----------------------------------------------------------------
  // primary oscillator configuration codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_LOW_POWER_XTAL = 3'h0;
  localparam logic [2:0] CFG_STANDARD_XTAL  = 3'h1;
  localparam logic [2:0] CFG_HIGH_SPEED_XTAL = 3'h2;
  localparam logic [2:0] CFG_RES_CAP        = 3'h3;
  localparam logic [2:0] CFG_INTERNAL_OSC   = 3'h4;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int         OST_CYCLES  = 1024;
  localparam logic [9:0] OST_LAST    = 10'(OST_CYCLES - 1);
  localparam int         SAMPLE_DIV  = 64;
  localparam logic [4:0] SAMPLE_HALF = 5'(SAMPLE_DIV / 2 - 1);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PWRUP, ST_OST, ST_WAIT_INT_FALL, ST_HOLD, ST_RUN, ST_INTERNAL, ST_FAILSAFE, ST_SLEEP
  } tssfc_fsm_t;

  typedef enum logic [1:0] {SRC_OFF, SRC_INT, SRC_EXT, SRC_TMR} tssfc_src_t;

  typedef struct packed {
    logic       dual_speed_switchover_enable;
    logic       fail_monitor_enable;
    logic       config_pll_force;
    logic       power_up_delay_timer_enable;
    logic [2:0] primary_osc_config;
  } tssfc_cfg_t;

  typedef struct packed {
    logic timer_osc_enable;
    logic timer_osc_ready;
    logic pll_ready;
    logic fast_osc_ready;
    logic fast_osc_locked;
    logic medium_osc_ready;
    logic slow_osc_ready;
    logic fast_osc_stable;
  } tssfc_osc_stat_t;

endpackage

// >>> core/tssfc_edge_det.sv
// edge detector for an oscillator level sampled on pclk
module tssfc_edge_det
  import tssfc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
  } tssfc_edge_t;

  tssfc_edge_t st_reg;
  tssfc_edge_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.prev = sig;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise = sig & ~st_reg.prev;
  assign fall = ~sig & st_reg.prev;

endmodule

// >>> core/tssfc_top.sv
// start-up timer, dual-speed switchover, fail-safe monitor and oscillator registers
// Summary of operation
// - two-speed only with switchover or fail monitor bit, select 00 and a crystal mode
// - start-up begins after power-on (after power-up delay) and each wake-up
// - during two-speed run internal clock while 1024 external cycles counted
// - on expiry wait internal fall, set done flag, hold low, switch on external fall
// - timer oscillator or crystal switch waits for 1024 counted cycles
// - fail monitor needs enable bit, covers external modes, acts after timer expiry
// - sample clock is slow internal oscillator divided by 64
// - detector latch set on external fall, cleared on sample rise
// - failure when a sample half-period passes with no external low
// - on failure switch to internal oscillator and set fail flag
// - interrupt only when fail flag and its enable are both set
// - stay on internal source until firmware restarts external clock
// - fail condition cleared by reset, sleep or changed clock select
// - clock select change restarts timer, internal until expiry, then external
// - fail flag cannot be cleared while fail condition holds
// - external input and RC modes skip the start-up timer
// - fail monitor enable also enables two-speed start-up
// - config PLL bit forces PLL on, else software bit controls it
// - 4-bit frequency select, resets to 0111
// - clock select 1x internal, 01 timer oscillator, 00 configured primary
// - done flag 1 on configured clock, 0 on internal oscillator
// - read-only ready, lock and stable bits of the oscillators
// - timer ready reads real readiness if enabled, else always 1
// - sleep aborts a start-up and leaves the done flag clear
//
// Local design decisions: the APB interface to the registers and the register addresses.
module tssfc_top
  import tssfc_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire tssfc_cfg_t      cfg,
  input  wire tssfc_osc_stat_t osc_stat,
  input  wire logic            power_up_done,
  input  wire logic            sleep_enter,
  input  wire logic            wake_up,
  input  wire logic            ext_osc_clk,
  input  wire logic            int_osc_clk,
  input  wire logic            timer_osc_clk,
  input  wire logic            slow_osc_clk,
  output tssfc_src_t           sys_clk_src,
  output logic [3:0]           internal_freq_select,
  output logic                 pll_enable,
  output logic                 start_up_done_flag,
  output logic                 osc_fail_flag,
  output logic                 osc_fail_irq,
  output logic                 fail_safe_active
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tssfc_fsm_t  fsm;
    tssfc_src_t  src;
    logic [7:0]  ctrl;
    logic        fail_flag;
    logic        fail_ien;
    logic        fail_cond;
    logic        su_done;
    logic        pll_en;
    logic        irq;
    logic [9:0]  ost_cnt;
    logic [4:0]  div_cnt;
    logic        sample_clk;
    logic        fd_latch;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tssfc_st_t;

  tssfc_st_t st_reg;
  tssfc_st_t st_next;

  logic ext_fall;
  logic int_fall;
  logic tmr_fall;
  logic slow_rise;

  // ----------------------------------------------------------------
  // oscillator edges
  // ----------------------------------------------------------------
  tssfc_edge_det u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (ext_osc_clk),
    .rise    (),
    .fall    (ext_fall)
  );

  tssfc_edge_det u_int (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (int_osc_clk),
    .rise    (),
    .fall    (int_fall)
  );

  tssfc_edge_det u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (timer_osc_clk),
    .rise    (),
    .fall    (tmr_fall)
  );

  tssfc_edge_det u_slow (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (slow_osc_clk),
    .rise    (slow_rise),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic       acc_rd;
  logic       acc_wr;
  logic       sel_ctrl;
  logic       sel_stat;
  logic       sel_fail;
  logic [1:0] clk_sel;
  logic       mon_fall;
  logic       crystal;
  logic       two_speed;
  logic       tmr_rdy_eff;
  logic       fail_detect;
  logic       sample_rise;
  logic       sample_fall;
  logic       sel_change;
  logic       do_start;
  logic [7:0] ctrl_wr;
  logic [7:0] status;

  assign sel_ctrl  = (paddr == OFS_OSC_CONTROL);
  assign sel_stat  = (paddr == OFS_OSC_STATUS);
  assign sel_fail  = (paddr == OFS_FAIL_CTRL);
  assign acc_rd    = psel & penable & ~st_reg.pready;
  assign acc_wr    = psel & penable & st_reg.pready & pwrite & pstrb[0];
  assign clk_sel   = st_reg.ctrl[POS_CLK_SEL +: 2];
  // external timebase being counted or monitored follows the clock select
  assign mon_fall  = (clk_sel == CLK_SEL_TIMER) ? tmr_fall : ext_fall;
  assign crystal   = (cfg.primary_osc_config == CFG_LOW_POWER_XTAL) |
                     (cfg.primary_osc_config == CFG_STANDARD_XTAL) |
                     (cfg.primary_osc_config == CFG_HIGH_SPEED_XTAL);
  assign two_speed = cfg.dual_speed_switchover_enable | cfg.fail_monitor_enable;
  assign tmr_rdy_eff = osc_stat.timer_osc_enable ? osc_stat.timer_osc_ready : 1'b1;
  assign ctrl_wr   = (pwdata[7:0] & CTRL_WR_MASK);
  assign sel_change = acc_wr & sel_ctrl & (ctrl_wr[POS_CLK_SEL +: 2] != clk_sel);

  // divide-by-64 sample clock: toggles every 32 slow oscillator rises
  assign sample_rise = slow_rise & (st_reg.div_cnt == SAMPLE_HALF) & ~st_reg.sample_clk;
  assign sample_fall = slow_rise & (st_reg.div_cnt == SAMPLE_HALF) & st_reg.sample_clk;
  // half-period check at sample fall; latch armed outside run so stale state never trips
  assign fail_detect = (st_reg.fsm == ST_RUN) & cfg.fail_monitor_enable &
                       sample_fall & ~st_reg.fd_latch & ~mon_fall;

  assign status = {tmr_rdy_eff, osc_stat.pll_ready, st_reg.su_done, osc_stat.fast_osc_ready,
                   osc_stat.fast_osc_locked, osc_stat.medium_osc_ready, osc_stat.slow_osc_ready,
                   osc_stat.fast_osc_stable};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    do_start = 1'b0;

    // sample clock divider runs freely
    if (slow_rise) begin
      if (st_reg.div_cnt == SAMPLE_HALF) begin
        st_next.div_cnt    = '0;
        st_next.sample_clk = ~st_reg.sample_clk;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 5'h1;
      end
    end

    // detector latch: set wins over clear
    if (st_reg.fsm != ST_RUN) begin
      st_next.fd_latch = 1'b1;
    end else if (mon_fall) begin
      st_next.fd_latch = 1'b1;
    end else if (sample_rise) begin
      st_next.fd_latch = 1'b0;
    end

    // register writes
    if (acc_wr && sel_ctrl) begin
      st_next.ctrl = ctrl_wr;
    end
    if (acc_wr && sel_fail) begin
      st_next.fail_ien = pwdata[BIT_FAIL_IEN];
      if (!pwdata[BIT_FAIL_FLAG] && !st_reg.fail_cond) begin
        st_next.fail_flag = 1'b0;
      end
    end

    unique case (st_reg.fsm)
      ST_PWRUP: begin
        if (!cfg.power_up_delay_timer_enable || power_up_done) begin
          do_start = 1'b1;
        end
      end
      ST_OST: begin
        if (mon_fall) begin
          if (st_reg.ost_cnt == OST_LAST) begin
            if (st_reg.src == SRC_INT) begin
              st_next.fsm = ST_WAIT_INT_FALL;
            end else begin
              st_next.src     = (clk_sel == CLK_SEL_TIMER) ? SRC_TMR : SRC_EXT;
              st_next.su_done = (clk_sel == CLK_SEL_PRIMARY);
              st_next.fsm     = ST_RUN;
            end
          end else begin
            st_next.ost_cnt = st_reg.ost_cnt + 10'h1;
          end
        end
      end
      ST_WAIT_INT_FALL: begin
        if (int_fall) begin
          st_next.su_done = (clk_sel == CLK_SEL_PRIMARY);
          st_next.src     = SRC_OFF;
          st_next.fsm     = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (mon_fall) begin
          st_next.src = (clk_sel == CLK_SEL_TIMER) ? SRC_TMR : SRC_EXT;
          st_next.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fail_detect) begin
          st_next.fail_cond = 1'b1;
          st_next.fail_flag = 1'b1;
          st_next.src       = SRC_INT;
          st_next.su_done   = 1'b0;
          st_next.fsm       = ST_FAILSAFE;
        end
      end
      ST_INTERNAL: begin
      end
      // only a select change, sleep or reset leaves here
      ST_FAILSAFE: begin
      end
      ST_SLEEP: begin
        if (wake_up) begin
          do_start = 1'b1;
        end
      end
    endcase

    if (sel_change && st_reg.fsm != ST_PWRUP && st_reg.fsm != ST_SLEEP) begin
      st_next.fail_cond = 1'b0;
      do_start          = 1'b1;
    end

    if (do_start) begin
      st_next.ost_cnt = '0;
      st_next.su_done = 1'b0;
      if (st_next.ctrl[POS_CLK_SEL + 1]) begin
        st_next.src = SRC_INT;
        st_next.fsm = ST_INTERNAL;
      end else if (st_next.ctrl[POS_CLK_SEL +: 2] == CLK_SEL_TIMER) begin
        st_next.src = SRC_INT;
        st_next.fsm = ST_OST;
      end else if (cfg.primary_osc_config == CFG_INTERNAL_OSC) begin
        st_next.src = SRC_INT;
        st_next.fsm = ST_INTERNAL;
      end else if (crystal) begin
        // without two-speed the core waits on a stopped clock
        st_next.src = two_speed ? SRC_INT : SRC_OFF;
        st_next.fsm = ST_OST;
      end else begin
        st_next.src     = SRC_EXT;
        st_next.su_done = 1'b1;
        st_next.fsm     = ST_RUN;
      end
    end

    if (sleep_enter) begin
      st_next.fsm       = ST_SLEEP;
      st_next.src       = SRC_OFF;
      st_next.su_done   = 1'b0;
      st_next.fail_cond = 1'b0;
    end

    st_next.pll_en = cfg.config_pll_force | st_next.ctrl[BIT_SOFT_PLL];
    st_next.irq    = st_next.fail_flag & st_next.fail_ien;

    // apb: one wait state, data prepared in the first access cycle
    st_next.pready  = acc_rd;
    st_next.pslverr = acc_rd & ~(sel_ctrl | sel_stat | sel_fail);
    st_next.prdata  = '0;
    if (acc_rd) begin
      if (sel_ctrl) begin
        st_next.prdata = {24'h000000, st_reg.ctrl};
      end else if (sel_stat) begin
        st_next.prdata = {24'h000000, status};
      end else if (sel_fail) begin
        st_next.prdata = {30'h0, st_reg.fail_ien, st_reg.fail_flag};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= '0;
      st_reg.fsm  <= ST_PWRUP;
      st_reg.src  <= SRC_INT;
      st_reg.ctrl <= CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata               = st_reg.prdata;
  assign pready               = st_reg.pready;
  assign pslverr              = st_reg.pslverr;
  assign sys_clk_src          = st_reg.src;
  assign internal_freq_select = st_reg.ctrl[POS_FREQ_SEL +: 4];
  assign pll_enable           = st_reg.pll_en;
  assign start_up_done_flag   = st_reg.su_done;
  assign osc_fail_flag        = st_reg.fail_flag;
  assign osc_fail_irq         = st_reg.irq;
  assign fail_safe_active     = st_reg.fail_cond;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PLL_FORCE: assert property (cfg.config_pll_force |=> pll_enable)
    else $error("pll not forced on");
  AST_IRQ_GATE: assert property (osc_fail_irq |-> $past(st_next.fail_flag & st_next.fail_ien))
    else $error("irq without enabled flag");
  AST_FAIL_SWITCH: assert property (fail_detect && !sleep_enter && !sel_change
                                    |=> sys_clk_src == SRC_INT && osc_fail_flag)
    else $error("failure not handled");
  AST_FLAG_HELD: assert property (fail_safe_active && osc_fail_flag && !sleep_enter |=> osc_fail_flag)
    else $error("flag cleared during fail condition");
  AST_SLEEP_ABORT: assert property (sleep_enter |=> !start_up_done_flag && !fail_safe_active
                                    && sys_clk_src == SRC_OFF)
    else $error("sleep did not abort start-up");
  AST_HOLD_LOW: assert property (st_reg.fsm == ST_HOLD |-> sys_clk_src == SRC_OFF)
    else $error("clock not held low");
  AST_OST_LEN: assert property (st_reg.fsm == ST_OST && $past(st_reg.fsm) != ST_OST
                                |-> st_reg.ost_cnt == 10'h000)
    else $error("start-up timer not restarted");
  AST_EXPIRY: assert property (st_reg.fsm == ST_OST && mon_fall && st_reg.ost_cnt == OST_LAST
                               && st_reg.src == SRC_INT && !sleep_enter && !sel_change
                               |=> st_reg.fsm == ST_WAIT_INT_FALL ##0 !start_up_done_flag)
    else $error("expiry sequence wrong");
  AST_MONITOR_OFF: assert property (!cfg.fail_monitor_enable |-> !fail_detect)
    else $error("monitor active while disabled");
  AST_SEL_CLEAR: assert property (sel_change && !sleep_enter && st_reg.fsm == ST_FAILSAFE
                                  |=> !fail_safe_active)
    else $error("select change kept fail condition");

  COV_FAIL: cover property (fail_detect);
  COV_SWITCH_DONE: cover property (st_reg.fsm == ST_HOLD ##1 st_reg.fsm == ST_RUN);
  COV_SLEEP_IN_OST: cover property (st_reg.fsm == ST_OST && sleep_enter);
  COV_FLAG_CLEARED: cover property (osc_fail_flag ##1 !osc_fail_flag);

endmodule

// >>> tb/tssfc_xosc_model.sv
// external crystal model: free-running square wave that can be stopped to fake a failure
module tssfc_xosc_model #(
  parameter int HALF = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      clk
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt;

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  // a dead crystal parks high, so no falling edge can keep the monitor happy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      clk <= 1'b0;
    end else if (!run) begin
      cnt <= 0;
      clk <= 1'b1;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      clk <= ~clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> tb/two_speed_start_fail_safe_clock_tb.sv
// self-checking bench for the start-up and fail-safe clock controller
module two_speed_start_fail_safe_clock_tb
  import tssfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic [3:0]      pstrb = 4'hF;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  tssfc_cfg_t      cfg = 7'h61;
  tssfc_osc_stat_t osc_stat = 8'h2D;
  logic            sleep_enter = 1'b0;
  logic            wake_up = 1'b0;
  logic            int_osc_clk = 1'b0;
  logic            slow_osc_clk = 1'b0;
  logic            ext_run = 1'b1;
  logic            ext_osc_clk;
  tssfc_src_t      sys_clk_src;
  logic [3:0]      internal_freq_select;
  logic            pll_enable;
  logic            start_up_done_flag;
  logic            osc_fail_flag;
  logic            osc_fail_irq;
  logic            fail_safe_active;
  int              failures = 0;
  int              cmp_count = 0;
  int              cyc = 0;
  logic [31:0]     rd;
  logic            er;

  always #25 pclk = ~pclk;

  // slow oscillator toggles every cycle: one sample half-period is 64 cycles
  always @(posedge pclk) begin
    slow_osc_clk <= ~slow_osc_clk;
    int_osc_clk <= cyc[1];
    cyc <= presetn ? cyc + 1 : 0;
  end

  tssfc_xosc_model tssfc_xosc_model_inst (.pclk(pclk), .presetn(presetn), .run(ext_run), .clk(ext_osc_clk));

  tssfc_top tssfc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
    .osc_stat(osc_stat), .power_up_done(1'b1), .sleep_enter(sleep_enter), .wake_up(wake_up),
    .ext_osc_clk(ext_osc_clk), .int_osc_clk(int_osc_clk), .timer_osc_clk(int_osc_clk), .slow_osc_clk(slow_osc_clk),
    .sys_clk_src(sys_clk_src), .internal_freq_select(internal_freq_select), .pll_enable(pll_enable),
    .start_up_done_flag(start_up_done_flag), .osc_fail_flag(osc_fail_flag), .osc_fail_irq(osc_fail_irq),
    .fail_safe_active(fail_safe_active)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never rewrites psel in the same step
    @(posedge pclk);
    if (n >= 20) begin
      failures++;
      $display("unexpected at %0t: bus answer missing", $time);
      wrap_up();
    end
  endtask

  task automatic wait_src(input tssfc_src_t s, input int lim);
    int n;
    n = 0;
    while (sys_clk_src !== s && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("unexpected at %0t: clock source wait ran out", $time);
      wrap_up();
    end
  endtask

  task automatic pulse(input logic slp);
    if (slp) sleep_enter <= 1'b1;
    else wake_up <= 1'b1;
    @(posedge pclk);
    sleep_enter <= 1'b0;
    wake_up <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk(sys_clk_src, SRC_INT);
    apb(1'b0, OFS_OSC_CONTROL, 32'h0);
    chk(rd, 32'h38);
    apb(1'b1, OFS_OSC_CONTROL, 32'hFC);
    apb(1'b0, OFS_OSC_CONTROL, 32'h0);
    chk(rd, 32'hF8);
    chk(pll_enable, 1'b1);
    chk(internal_freq_select, 4'hF);
    apb(1'b1, OFS_OSC_CONTROL, 32'h38);
    apb(1'b0, OFS_OSC_STATUS, 32'h0);
    chk(rd, 32'hCD);
    apb(1'b0, 12'h00C, 32'h0);
    chk(er, 1'b1);
  endtask

  task automatic t_startup;
    wait_src(SRC_EXT, 6000);
    chk(cyc > 4000, 1'b1);
    chk(start_up_done_flag, 1'b1);
    apb(1'b0, OFS_OSC_STATUS, 32'h0);
    chk(rd, 32'hED);
  endtask

  task automatic t_fail;
    apb(1'b1, OFS_FAIL_CTRL, 32'h2);
    ext_run <= 1'b0;
    wait_src(SRC_INT, 400);
    chk({osc_fail_flag, fail_safe_active}, 2'b11);
    repeat (2) @(posedge pclk);
    chk(osc_fail_irq, 1'b1);
    apb(1'b1, OFS_FAIL_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk(osc_fail_irq, 1'b0);
    apb(1'b0, OFS_FAIL_CTRL, 32'h0);
    chk(rd, 32'h1);
    ext_run <= 1'b1;
    repeat (300) @(posedge pclk);
    chk(sys_clk_src, SRC_INT);
  endtask

  task automatic t_select;
    apb(1'b1, OFS_OSC_CONTROL, 32'h3A);
    repeat (2) @(posedge pclk);
    chk(fail_safe_active, 1'b0);
    apb(1'b1, OFS_OSC_CONTROL, 32'h38);
    repeat (2000) @(posedge pclk);
    chk(sys_clk_src, SRC_INT);
    wait_src(SRC_EXT, 4000);
    apb(1'b1, OFS_FAIL_CTRL, 32'h0);
    apb(1'b0, OFS_FAIL_CTRL, 32'h0);
    chk(rd, 32'h0);
    // timer oscillator path shares the internal waveform
    apb(1'b1, OFS_OSC_CONTROL, 32'h39);
    repeat (100) @(posedge pclk);
    chk(sys_clk_src, SRC_INT);
    wait_src(SRC_TMR, 6000);
    chk(start_up_done_flag, 1'b0);
    apb(1'b1, OFS_OSC_CONTROL, 32'h38);
  endtask

  task automatic t_sleep;
    pulse(1'b1);
    chk({sys_clk_src, start_up_done_flag}, {SRC_OFF, 1'b0});
    pulse(1'b0);
    chk(sys_clk_src, SRC_INT);
    repeat (100) @(posedge pclk);
    pulse(1'b1);
    chk({sys_clk_src, start_up_done_flag}, {SRC_OFF, 1'b0});
    pulse(1'b0);
    wait_src(SRC_EXT, 6000);
    chk(start_up_done_flag, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_startup();
    t_fail();
    t_select();
    t_sleep();
    wrap_up();
  end
endmodule
